/* common/dtr_defines.vh */
// Purpose: constants for the detector restart block
// Assumes: 50 MHz clock, 32-bit APB register window
// Notes: offsets are byte addresses
`ifndef DTR_DEFINES_VH
`define DTR_DEFINES_VH
// register offsets
`define DTR_OFF_CFG 12'h000
`define DTR_OFF_CTRL 12'h004
`define DTR_OFF_STAT 12'h008
`define DTR_OFF_DELAY 12'h00C
// restart settings
`define DTR_SET_NONE 2'h0
`define DTR_SET_DIS 2'h1
`define DTR_SET_DET 2'h2
`define DTR_SET_PREV 2'h3
// operating states
`define DTR_ST_IDLE 2'h0
`define DTR_ST_DIS 2'h1
`define DTR_ST_DET 2'h2
// application types
`define DTR_APP_SINGLE 2'h0
`define DTR_APP_MAIN 2'h1
// cfg field positions
`define DTR_CFG_BUS_LO 0
`define DTR_CFG_PRG_LO 2
`define DTR_CFG_APP_LO 4
`define DTR_CFG_COUPLE 6
`define DTR_CFG_BRDEP 7
`define DTR_CFG_DISTX 8
`define DTR_CFG_RST 32'h0000_0000
// ctrl bits (write 1 pulses)
`define DTR_CTL_BUSRET 0
`define DTR_CTL_PROG 1
`define DTR_CTL_MOTION 2
`define DTR_CTL_DISON 3
`define DTR_CTL_DISOFF 4
// transmission delay default, in ms
`define DTR_DELAY_MS 32'h0000_EA60
`define DTR_CLK_KHZ 32'h0000_C350
`endif

/* verilog/dtr_restart.v */
// Purpose: restart behaviour of one motion detection block
// Assumes: registers over APB, single clock, sync reset
// Notes: RST models power-on only; the retained state survives RST
`timescale 1ns/1ps
`default_nettype none
`include "dtr_defines.vh"

// overview of the restart path
// two restart events exist: supply return and configuration download
// both arrive as single write pulses on the control word
// download wins when both pulse in one write
// a download never applies the previous-state option
// an inactive block ignores both events entirely
// application types other than single or main ignore them too
//
// operating states
// idle: no motion, delay timer parked at zero
// disabled: no detection, delay timer parked at zero
// detecting: delay timer counting down once per clock
//
// retained state
// saved_reg mirrors the operating state while the block runs
// it is frozen from reset until the first restart is applied
// so the previous-state option sees the state before the outage
// it is never cleared, only refreshed after the restart
// a simulator starts it unknown; the case default maps that to idle
//
// delay timer
// loaded with the full transmission delay on every detection start
// a fresh motion pulse reloads it, so detection stretches
// expiry without motion ends detection with the end telegram
// coupled operation withdraws presence instead of sending
//
// brightness handling
// independent mode when detection does not depend on brightness
// independent mode when restoring a stored detection
// independent mode when the room is below twilight level
// otherwise an uncoupled detection restart clears indep_reg to dependent mode
//
// switch-off delay
// a restart always stops it; it is never resumed by a restart
// it rearms only while the off-threshold level is seen
// and only while detection is running
// the threshold pin is synchronised, so this lags by two clocks
//
// pin inputs
// activity and both brightness levels are asynchronous levels
// each passes two flip-flops before any logic reads it
// a restart within two clocks of activation may still be skipped
//
// register bus
// zero wait states: ready is tied high
// writes land at the access edge, reactions at that same edge
// reads come from a plain mux over the held address
// unmapped reads give zero, unmapped writes do nothing
// error response is never raised
//
// telegram outputs
// start, end and disable-start are one-clock pulses
// presence and disable toward light control are levels
// disable-start telegram only when enabled in the settings word
// coupled operation forwards disable instead of sending
//
// limitations
// light control reactions are outside this block
// group switch-over and walking test appear only as inactivity
// repeated disable requests repeat the disable reaction
// a disable release returns to idle without telegrams
//
// trade-offs
// one shared timer keeps area small; no separate evaluation delay
// reset covers power-on only; the retained copy must survive it

module dtr_restart #(
    parameter IS_FIRST_BLOCK = 1,
    parameter [31:0] DELAY_CYCLES = `DTR_DELAY_MS * `DTR_CLK_KHZ
) (
    // clock and reset
    input wire CLK,
    input wire RST,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    // block status pins
    input wire BLOCK_ACTIVE,
    input wire BRIGHT_BELOW_TWILIGHT,
    input wire BRIGHT_ABOVE_OFF_THR,
    // telegram and light control outputs
    output reg TX_DET_START,
    output reg TX_DET_END,
    output reg TX_DIS_START,
    output reg PRESENCE_TO_LC,
    output reg DISABLE_TO_LC,
    output reg SWOFF_DELAY_RUN
);

    reg [31:0] cfg_reg;
    reg [1:0] state_reg;
    reg [1:0] saved_reg; // retained copy, not cleared by RST
    reg [1:0] restore_reg; // state before disable; never read, a release always returns to idle
    reg indep_reg;
    reg [31:0] delay_reg;
    reg [31:0] delay_next;
    reg [1:0] act_next;
    reg ev_busret, ev_prog;
    reg coupled, eligible, trig;
    reg hold_reg; // freezes the retained copy until a restart ran
    wire wr = PSEL && PENABLE && PWRITE;
    wire brin_1, off_1, act_1;
    reg [2:0] sync_a_reg, sync_b_reg;
    wire [1:0] bus_set = cfg_reg[`DTR_CFG_BUS_LO +: 2];
    wire [1:0] prg_set = cfg_reg[`DTR_CFG_PRG_LO +: 2];
    wire [1:0] app = cfg_reg[`DTR_CFG_APP_LO +: 2];

    // compare register address with one offset for reads and writes
    function hit;
        input [11:0] a;
        input [11:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // two-flop sync of the pin levels
    always @(posedge CLK) begin
        sync_a_reg <= {BLOCK_ACTIVE, BRIGHT_BELOW_TWILIGHT,
            BRIGHT_ABOVE_OFF_THR};
        sync_b_reg <= sync_a_reg;
    end
    assign act_1 = sync_b_reg[2];
    assign brin_1 = sync_b_reg[1];
    assign off_1 = sync_b_reg[0];

    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;

    // read mux
    always @* begin
        PRDATA = 32'h0000_0000;
        if (hit(PADDR, `DTR_OFF_CFG)) PRDATA = cfg_reg;
        else if (hit(PADDR, `DTR_OFF_STAT))
            PRDATA = {26'h000_0000, indep_reg, PRESENCE_TO_LC,
                saved_reg, state_reg};
        else if (hit(PADDR, `DTR_OFF_DELAY)) PRDATA = delay_reg;
    end

    // restart decision
    always @* begin
        ev_busret = wr && hit(PADDR, `DTR_OFF_CTRL) &&
            PWDATA[`DTR_CTL_BUSRET];
        ev_prog = wr && hit(PADDR, `DTR_OFF_CTRL) &&
            PWDATA[`DTR_CTL_PROG];
        coupled = cfg_reg[`DTR_CFG_COUPLE] && (IS_FIRST_BLOCK != 0);
        eligible = act_1 && (app == `DTR_APP_SINGLE ||
            app == `DTR_APP_MAIN);
        trig = 1'b0;
        act_next = `DTR_SET_NONE;
        if (ev_prog && eligible) begin
            trig = 1'b1;
            act_next = (prg_set == `DTR_SET_PREV) ? `DTR_SET_NONE
                : prg_set;
        end else if (ev_busret && eligible) begin
            trig = 1'b1;
            act_next = bus_set;
            if (bus_set == `DTR_SET_PREV) begin
                case (saved_reg)
                    `DTR_ST_DIS: act_next = `DTR_SET_DIS;
                    `DTR_ST_DET: act_next = `DTR_SET_DET;
                    default: act_next = `DTR_SET_NONE;
                endcase
            end
        end
    end

    // config and retained state; saved_reg has no reset on purpose
    // the copy stays frozen from reset to the first restart, else
    // the idle state after reset would overwrite the stored one
    always @(posedge CLK) begin
        if (RST) cfg_reg <= `DTR_CFG_RST;
        else if (wr && hit(PADDR, `DTR_OFF_CFG)) cfg_reg <= PWDATA;
        if (RST) hold_reg <= 1'b1;
        else if (trig) hold_reg <= 1'b0;
        if (!RST && !hold_reg) saved_reg <= state_reg;
    end

    // operating state, delay timer and outputs
    always @(posedge CLK) begin
        if (RST) begin
            state_reg <= `DTR_ST_IDLE;
            restore_reg <= `DTR_ST_IDLE;
            indep_reg <= 1'b0;
            delay_reg <= 32'h0000_0000;
            TX_DET_START <= 1'b0;
            TX_DET_END <= 1'b0;
            TX_DIS_START <= 1'b0;
            PRESENCE_TO_LC <= 1'b0;
            DISABLE_TO_LC <= 1'b0;
            SWOFF_DELAY_RUN <= 1'b0;
        end else begin
            TX_DET_START <= 1'b0;
            TX_DET_END <= 1'b0;
            TX_DIS_START <= 1'b0;
            if (trig) begin
                SWOFF_DELAY_RUN <= 1'b0;
                DISABLE_TO_LC <= 1'b0;
                case (act_next)
                    `DTR_SET_DIS: begin
                        state_reg <= `DTR_ST_DIS;
                        restore_reg <= `DTR_ST_IDLE;
                        delay_reg <= 32'h0000_0000;
                        PRESENCE_TO_LC <= 1'b0;
                        if (coupled) DISABLE_TO_LC <= 1'b1;
                        else TX_DIS_START <=
                            cfg_reg[`DTR_CFG_DISTX];
                    end
                    `DTR_SET_DET: begin
                        state_reg <= `DTR_ST_DET;
                        delay_reg <= DELAY_CYCLES;
                        if (coupled) PRESENCE_TO_LC <= 1'b1;
                        else begin
                            TX_DET_START <= 1'b1;
                            indep_reg <= ~cfg_reg[`DTR_CFG_BRDEP]
                                || (bus_set == `DTR_SET_PREV &&
                                !ev_prog) || brin_1;
                        end
                    end
                    default: begin
                        state_reg <= `DTR_ST_IDLE;
                        delay_reg <= 32'h0000_0000;
                        PRESENCE_TO_LC <= 1'b0;
                    end
                endcase
            end else begin
                // runtime motion and disable control
                if (wr && hit(PADDR, `DTR_OFF_CTRL)) begin
                    if (PWDATA[`DTR_CTL_DISON]) begin
                        restore_reg <= state_reg;
                        state_reg <= `DTR_ST_DIS;
                        delay_reg <= 32'h0000_0000;
                        if (coupled) DISABLE_TO_LC <= 1'b1;
                        else TX_DIS_START <= cfg_reg[`DTR_CFG_DISTX];
                    end else if (PWDATA[`DTR_CTL_DISOFF] &&
                            state_reg == `DTR_ST_DIS) begin
                        state_reg <= `DTR_ST_IDLE;
                        DISABLE_TO_LC <= 1'b0;
                        PRESENCE_TO_LC <= 1'b0;
                    end else if (PWDATA[`DTR_CTL_MOTION] &&
                            state_reg != `DTR_ST_DIS) begin
                        if (state_reg == `DTR_ST_IDLE)
                            TX_DET_START <= !coupled;
                        state_reg <= `DTR_ST_DET;
                        delay_reg <= DELAY_CYCLES;
                        PRESENCE_TO_LC <= coupled;
                    end
                end else if (state_reg == `DTR_ST_DET) begin
                    if (delay_reg <= 32'h0000_0001) begin
                        state_reg <= `DTR_ST_IDLE;
                        delay_reg <= 32'h0000_0000;
                        TX_DET_END <= !coupled;
                        PRESENCE_TO_LC <= 1'b0;
                    end else begin
                        delay_reg <= delay_reg - 32'h0000_0001;
                    end
                end
                // switch-off delay rearms while the threshold level is seen in detection
                if (off_1 && state_reg == `DTR_ST_DET)
                    SWOFF_DELAY_RUN <= 1'b1;
                else if (!off_1)
                    SWOFF_DELAY_RUN <= 1'b0;
            end
        end
    end

endmodule // dtr_restart
`default_nettype wire

/* test/dtr_restart_props.sv */
// Purpose: pin-level assertions for the restart block
// Assumes: settings tracked from apb writes to the settings word
// Notes: reactions land one to two edges after the access edge
`timescale 1ns/1ps
`default_nettype none
module dtr_restart_props (
    // clock, reset and bus
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic BLOCK_ACTIVE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    // reactions
    input wire logic TX_DET_START,
    input wire logic TX_DIS_START,
    input wire logic PRESENCE_TO_LC,
    input wire logic DISABLE_TO_LC
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    logic [8:0] cfg_q;
    logic [2:0] act_q;
    wire wr = PSEL && PENABLE && PWRITE && PADDR == 12'h004;
    wire ret = wr && PWDATA[0] && !PWDATA[1];
    wire prg = wr && PWDATA[1];
    wire ok = BLOCK_ACTIVE && (&act_q) && cfg_q[5:4] < 2'h2;
    wire off = !BLOCK_ACTIVE && !(|act_q);
    // settings copy; activity must outlast the pin sync
    always @(posedge CLK) begin
        act_q <= {act_q[1:0], BLOCK_ACTIVE};
        if (RST)
            cfg_q <= 9'h000;
        else if (PSEL && PENABLE && PWRITE && PADDR == 12'h000)
            cfg_q <= PWDATA[8:0];
    end
    sequence quiet;
        (!TX_DET_START && !TX_DIS_START) [*3];
    endsequence
    a_none_silent: assert property (ret && ok && cfg_q[1:0] == 2'h0 |-> ##1 quiet)
        else $error("silent restart sent a telegram");
    a_none_no_presence: assert property (ret && ok && cfg_q[6] && cfg_q[1:0] == 2'h0 |-> ##2 !PRESENCE_TO_LC [*2])
        else $error("presence left on after silent restart");
    a_disable_sent: assert property (ret && ok && cfg_q[8:6] == 3'h4 && cfg_q[1:0] == 2'h1 |-> ##[1:2] TX_DIS_START)
        else $error("disable start telegram missing");
    a_disable_fwd: assert property (ret && ok && cfg_q[6] && cfg_q[1:0] == 2'h1 |-> ##2 DISABLE_TO_LC)
        else $error("disable not forwarded");
    a_detect_start: assert property (ret && ok && !cfg_q[6] && cfg_q[1:0] == 2'h2 |-> ##[1:2] TX_DET_START)
        else $error("detection start telegram missing");
    a_detect_lc: assert property (ret && ok && cfg_q[6] && cfg_q[1:0] == 2'h2 |-> ##2 PRESENCE_TO_LC)
        else $error("presence not raised");
    a_skip_idle: assert property (wr && PWDATA[0] && off |-> ##1 quiet)
        else $error("inactive block reacted");
    a_app_gate: assert property (ret && BLOCK_ACTIVE && (&act_q) && cfg_q[5:4] > 2'h1 |-> ##1 quiet)
        else $error("restart reacted for other application");
    a_prog_detect: assert property (prg && ok && !cfg_q[6] && cfg_q[3:2] == 2'h2 |-> ##[1:2] TX_DET_START)
        else $error("programming restart did not start detection");
endmodule // dtr_restart_props
`default_nettype wire

/* test/dtr_far_side.sv */
// Purpose: actuator side model counting the telegrams received
// Assumes: each telegram pin pulses one cycle
// Notes: totals never clear, so a supply loss keeps them
`timescale 1ns/1ps
`default_nettype none
module dtr_far_side (
    // clock and telegram pins
    input wire logic CLK,
    input wire logic DET_START,
    input wire logic DET_END,
    input wire logic DIS_START,
    // running totals
    output var logic [31:0] N_DET,
    output var logic [31:0] N_END,
    output var logic [31:0] N_DIS
);
    initial {N_DET, N_END, N_DIS} = '0;
    // one count for every pulse sampled
    always @(posedge CLK) begin
        N_DET <= N_DET + {31'h0, DET_START};
        N_END <= N_END + {31'h0, DET_END};
        N_DIS <= N_DIS + {31'h0, DIS_START};
    end
endmodule // dtr_far_side
`default_nettype wire

/* test/test_dtr_restart.sv */
// Purpose: sequence of restarts with expected reactions
// Assumes: shortened transmission delay of 20 cycles
// Notes: telegram totals come from the far side model
`timescale 1ns/1ps
`default_nettype none
`include "dtr_defines.vh"
module test_dtr_restart;
    logic clk, rst, psel, pen, pwr, act, dark, above;
    logic [11:0] paddr;
    logic [31:0] pwdata, r, n_det, n_end, n_dis;
    wire logic [31:0] prdata;
    wire logic pready, tds, tde, tdi, pres, dlc, swoff;
    int miscompares = 0, num_checks = 0, cyc = 0;
    dtr_restart #(.DELAY_CYCLES(32'h0000_0014)) u_dtr_restart (.CLK(clk),
        .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(),
        .BLOCK_ACTIVE(act), .BRIGHT_BELOW_TWILIGHT(dark),
        .BRIGHT_ABOVE_OFF_THR(above), .TX_DET_START(tds), .TX_DET_END(tde),
        .TX_DIS_START(tdi), .PRESENCE_TO_LC(pres), .DISABLE_TO_LC(dlc),
        .SWOFF_DELAY_RUN(swoff));
    dtr_far_side u_dtr_far_side (.CLK(clk), .DET_START(tds), .DET_END(tde),
        .DIS_START(tdi), .N_DET(n_det), .N_END(n_end), .N_DIS(n_dis));
    task close_out;
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("[FAIL] %s exp %h got %h", n, e, g);
            miscompares++;
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input [11:0] a, input w, input [31:0] d);
        @(posedge clk);
        psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        psel <= 0; pen <= 0;
    endtask
    task rd(input [11:0] a, input [31:0] e, input [31:0] m);
        apb(a, 0, 0);
        chk("read", e, r & m);
    endtask
    // set up, trigger a restart, then compare state and telegram counts
    task run(input [8:0] c, input [1:0] k, st, input [31:0] dd, ds);
        logic [31:0] b0, b1;
        b0 = n_det; b1 = n_dis;
        apb(`DTR_OFF_CFG, 1, {23'h0, c});
        apb(`DTR_OFF_CTRL, 1, {30'h0, k});
        repeat (3) @(posedge clk);
        rd(`DTR_OFF_STAT, {30'h0, st}, 32'h0000_0003);
        chk("det_tx", b0 + dd, n_det);
        chk("dis_tx", b1 + ds, n_dis);
    endtask
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            close_out;
        end
    end
    initial begin
        {psel, pen, pwr, paddr, pwdata, dark, above} = '0;
        rst = 1; act = 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        rd(`DTR_OFF_CFG, 0, 32'hFFFF_FFFF);
        rd(12'h010, 0, 32'hFFFF_FFFF);
        run(9'h100, 1, 0, 0, 0);
        run(9'h101, 1, 1, 0, 1);
        run(9'h102, 1, 2, 1, 0);
        repeat (25) @(posedge clk);
        chk("end_tx", 1, n_end);
        run(9'h142, 1, 2, 0, 0);
        chk("presence", 1, {31'h0, pres});
        run(9'h140, 1, 0, 0, 0);
        chk("presence", 0, {31'h0, pres});
        run(9'h141, 1, 1, 0, 0);
        chk("dis_lc", 1, {31'h0, dlc});
        run(9'h122, 1, 1, 0, 0);
        run(9'h109, 3, 2, 1, 0);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        run(9'h103, 1, 2, 1, 0);
        chk("swoff", 0, {31'h0, swoff});
        above <= 1;
        repeat (4) @(posedge clk);
        chk("swoff", 1, {31'h0, swoff});
        above <= 0;
        run(9'h100, 1, 0, 0, 0);
        act <= 0;
        run(9'h102, 1, 0, 0, 0);
        act <= 1; dark <= 1;
        run(9'h182, 1, 2, 1, 0);
        rd(`DTR_OFF_STAT, 32'h0000_0020, 32'h0000_0020);
        close_out;
    end
endmodule // test_dtr_restart
bind dtr_restart dtr_restart_props u_dtr_restart_props (.CLK(CLK),
    .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .BLOCK_ACTIVE(BLOCK_ACTIVE), .PADDR(PADDR), .PWDATA(PWDATA),
    .TX_DET_START(TX_DET_START), .TX_DIS_START(TX_DIS_START),
    .PRESENCE_TO_LC(PRESENCE_TO_LC), .DISABLE_TO_LC(DISABLE_TO_LC));
`default_nettype wire
